// [rtl/scs_edge_counter.sv]
`timescale 1ns/100ps
`default_nettype none
`include "scs_defs.svh"
module scs_edge_counter (
    input wire logic clock,
    input wire logic rst_n,
    scs_cnt_if.cnt cif
);
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic lvl_q;
    logic lvl_d;
    logic done_q;
    logic done_d;

    // Derived clock is sampled, so it must run below half of clock
    always_comb begin
        // Idle high, so a newly selected clock never counts a false edge
        lvl_d = cif.start ? cif.clk_lvl : 1'b1;
        cnt_d = cnt_q;
        done_d = 1'b0;
        if (!cif.start) begin
            cnt_d = 4'h0;
        end else if (cnt_q == `SCS_SEQ_GAP) begin
            done_d = 1'b1;
        end else if (cif.clk_lvl && !lvl_q) begin
            cnt_d = cnt_q + 4'h1;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cnt_q <= 4'h0;
            lvl_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            lvl_q <= lvl_d;
            done_q <= done_d;
        end
    end

    assign cif.done = done_q;
endmodule : scs_edge_counter
`default_nettype wire

// [rtl/scs_sequencer.sv]
// Contract
// [R1] With safe startup on, output gates stay shut until lock is seen high on eight consecutive cycles.
// [R2] With sequencing on, enabled outputs open in ascending order of their sequence numbers.
// [R3] Between opening one output and the next, eight cycles of the later output clock pass.
// [R4] A selection control switches the reference between the primary and secondary input clock.
// [R5] With spread spectrum on, the secondary input, power minimisation and reconfiguration are unavailable.
// [R6] Spread spectrum is refused with power minimisation, with reconfiguration, or off the multi-mode variant.
// [R7] Minimum output jitter and maximum input filtering exclude each other, balanced being the alternative.
// [R8] Reconfiguration goes through the AXI4-Lite slave by default, or the primitive config port if chosen.
// [R9] The integrator supplies 10 to 1066 MHz input, or 25 to 150 MHz with spread spectrum.
// [R10] Reset or loss of lock shuts all gates and restarts qualification and sequence; the code shuts gates on lock loss only with safe startup on.
`timescale 1ns/100ps
`default_nettype none
`include "scs_defs.svh"
module scs_sequencer #(
    parameter int NUM_OUT = 7,
    parameter int SEQ_W = 3,
    parameter bit MULTI_MODE = 1'b1
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`SCS_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic locked,
    input wire logic [NUM_OUT-1:0] clk_out_mon,
    output logic [NUM_OUT-1:0] gate_en,
    output logic clk_sel,
    output logic ss_en,
    output logic pwr_min_en,
    output logic [1:0] bw_mode,
    output logic reconfig_axi_en,
    output logic primitive_config_port_en
);
    if (NUM_OUT < 1 || NUM_OUT > 8 || SEQ_W < 1 || NUM_OUT * SEQ_W > 32) begin : g_bad_params
        $error("scs_sequencer: unsupported NUM_OUT or SEQ_W");
    end

    localparam int SEQ_BITS = NUM_OUT * SEQ_W;

    // ***********************************
    // Helpers
    // ***********************************
    function automatic logic [NUM_OUT-1:0] level_mask(
        input logic [SEQ_W:0] lvl,
        input logic [NUM_OUT-1:0] en,
        input logic [SEQ_BITS-1:0] seq
    );
        logic [NUM_OUT-1:0] m;
        m = '0;
        for (int i = 0; i < NUM_OUT; i++) begin
            m[i] = en[i] && ({1'b0, seq[i*SEQ_W +: SEQ_W]} == lvl);
        end
        return m;
    endfunction : level_mask

    function automatic logic [2:0] lowest(input logic [NUM_OUT-1:0] m);
        logic [2:0] idx;
        idx = 3'h0;
        for (int i = NUM_OUT - 1; i >= 0; i--) begin
            if (m[i]) begin
                idx = 3'(i);
            end
        end
        return idx;
    endfunction : lowest

    function automatic logic cfg_ok(input logic [`SCS_CTRL_W-1:0] v);
        logic ok;
        ok = 1'b1;
        // [R6] SS exclusions
        if (v[`SCS_CB_SS] && (v[`SCS_CB_PWR_MIN] || v[`SCS_CB_DYN] || !MULTI_MODE)) begin
            ok = 1'b0;
        end
        // [R5] SS bars secondary input
        if (v[`SCS_CB_SS] && v[`SCS_CB_CLK_SEL]) begin
            ok = 1'b0;
        end
        // [R7] One jitter goal only
        if (v[`SCS_CB_BW_HI:`SCS_CB_BW_LO] == `SCS_BW_ILLEGAL) begin
            ok = 1'b0;
        end
        return ok;
    endfunction : cfg_ok

    // ***********************************
    // APB slave and registers
    // ***********************************
    logic [`SCS_CTRL_W-1:0] cfg_q, cfg_d;
    logic [NUM_OUT-1:0] out_en_q, out_en_d;
    logic [SEQ_BITS-1:0] seq_q, seq_d;
    logic [31:0] prdata_q, prdata_d;
    logic pready_q, pready_d;
    logic pslverr_q, pslverr_d;
    logic [NUM_OUT-1:0] gate_q, gate_d;
    logic qual;
    scs_pkg::scs_state_t st_q, st_d;

    // One wait state: decode in the first access cycle, answer in the second
    always_comb begin
        cfg_d = cfg_q;
        out_en_d = out_en_q;
        seq_d = seq_q;
        prdata_d = prdata_q;
        pslverr_d = 1'b0;
        pready_d = psel && penable && !pready_q;
        if (pready_d) begin
            prdata_d = 32'h0;
            case (paddr)
                `SCS_OFF_CTRL: begin
                    prdata_d[`SCS_CTRL_W-1:0] = cfg_q;
                    pslverr_d = pwrite && !cfg_ok(pwdata[`SCS_CTRL_W-1:0]);
                end
                `SCS_OFF_OUT_EN: begin
                    prdata_d[NUM_OUT-1:0] = out_en_q;
                end
                `SCS_OFF_SEQ: begin
                    prdata_d[SEQ_BITS-1:0] = seq_q;
                end
                `SCS_OFF_STATUS: begin
                    prdata_d[NUM_OUT-1:0] = gate_q;
                    prdata_d[`SCS_SB_LOCKED] = locked;
                    prdata_d[`SCS_SB_QUAL] = qual;
                    prdata_d[`SCS_SB_DONE] = (st_q == scs_pkg::SCS_DONE);
                    pslverr_d = pwrite;
                end
                default: begin
                    pslverr_d = 1'b1;
                end
            endcase
        end
        // Commit at the edge where the master sees pready
        if (psel && penable && pready_q && pwrite && !pslverr_q) begin
            case (paddr)
                `SCS_OFF_CTRL: cfg_d = pwdata[`SCS_CTRL_W-1:0];
                `SCS_OFF_OUT_EN: out_en_d = pwdata[NUM_OUT-1:0];
                `SCS_OFF_SEQ: seq_d = pwdata[SEQ_BITS-1:0];
                default: cfg_d = cfg_q;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cfg_q <= `SCS_CTRL_RST;
            out_en_q <= '0;
            seq_q <= '0;
            prdata_q <= 32'h0;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            cfg_q <= cfg_d;
            out_en_q <= out_en_d;
            seq_q <= seq_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    // ***********************************
    // Lock qualification
    // ***********************************
    logic [3:0] lock_cnt_q, lock_cnt_d;

    always_comb begin
        // [R1] Eight consecutive samples
        if (!locked) begin
            lock_cnt_d = 4'h0;
        end else if (lock_cnt_q == `SCS_LOCK_CYCLES) begin
            lock_cnt_d = lock_cnt_q;
        end else begin
            lock_cnt_d = lock_cnt_q + 4'h1;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            lock_cnt_q <= 4'h0;
        end else begin
            lock_cnt_q <= lock_cnt_d;
        end
    end

    assign qual = (lock_cnt_q == `SCS_LOCK_CYCLES);

    // ***********************************
    // Output sequence
    // ***********************************
    logic [SEQ_W:0] lvl_q, lvl_d;
    logic [2:0] idx_q, idx_d;
    logic [NUM_OUT-1:0] pend;
    scs_cnt_if cif ();

    assign cif.start = (st_q == scs_pkg::SCS_WAIT);
    assign cif.clk_lvl = clk_out_mon[idx_q];

    scs_edge_counter u_gap (
        .clock(clock),
        .rst_n(rst_n),
        .cif(cif)
    );

    always_comb begin
        st_d = st_q;
        lvl_d = lvl_q;
        idx_d = idx_q;
        gate_d = gate_q;
        pend = level_mask(lvl_q, out_en_q, seq_q) & ~gate_q;
        if (!cfg_q[`SCS_CB_SAFE]) begin
            // Without safe startup the gates follow the enables directly
            gate_d = out_en_q;
            st_d = scs_pkg::SCS_QUAL;
            lvl_d = '0;
        end else if (!locked) begin
            // [R10] Lock lost: shut and restart
            gate_d = '0;
            st_d = scs_pkg::SCS_QUAL;
            lvl_d = '0;
        end else begin
            case (st_q)
                scs_pkg::SCS_QUAL: begin
                    gate_d = '0;
                    lvl_d = '0;
                    // [R1] Open only when qualified
                    if (qual) begin
                        if (cfg_q[`SCS_CB_SEQ]) begin
                            st_d = scs_pkg::SCS_FIND;
                        end else begin
                            gate_d = out_en_q;
                            st_d = scs_pkg::SCS_DONE;
                        end
                    end
                end
                scs_pkg::SCS_FIND: begin
                    // [R2] Ascending sequence numbers
                    if (lvl_q[SEQ_W]) begin
                        st_d = scs_pkg::SCS_DONE;
                    end else if (pend == '0) begin
                        lvl_d = lvl_q + 1'b1;
                    end else if (gate_q == '0) begin
                        gate_d = gate_q | pend;
                        lvl_d = lvl_q + 1'b1;
                    end else begin
                        idx_d = lowest(pend);
                        st_d = scs_pkg::SCS_WAIT;
                    end
                end
                scs_pkg::SCS_WAIT: begin
                    // [R3] Gap counted on the later clock
                    if (cif.done) begin
                        gate_d = gate_q | pend;
                        lvl_d = lvl_q + 1'b1;
                        st_d = scs_pkg::SCS_FIND;
                    end
                end
                scs_pkg::SCS_DONE: begin
                    gate_d = gate_q & out_en_q;
                end
                default: begin
                    st_d = scs_pkg::SCS_QUAL;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            // [R10] Reset shuts all gates
            st_q <= scs_pkg::SCS_QUAL;
            lvl_q <= '0;
            idx_q <= 3'h0;
            gate_q <= '0;
        end else begin
            st_q <= st_d;
            lvl_q <= lvl_d;
            idx_q <= idx_d;
            gate_q <= gate_d;
        end
    end

    // ***********************************
    // Primitive controls
    // ***********************************
    logic axi_q, axi_d;
    logic port_q, port_d;

    always_comb begin
        // [R8] AXI4-Lite unless the config port is chosen
        // Taken from the next config, so these switch with the write, never lagging spread spectrum
        axi_d = cfg_d[`SCS_CB_DYN] && !cfg_d[`SCS_CB_PORT];
        port_d = cfg_d[`SCS_CB_DYN] && cfg_d[`SCS_CB_PORT];
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            axi_q <= 1'b0;
            port_q <= 1'b0;
        end else begin
            axi_q <= axi_d;
            port_q <= port_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign gate_en = gate_q;
    // [R4] Reference select
    assign clk_sel = cfg_q[`SCS_CB_CLK_SEL];
    assign ss_en = cfg_q[`SCS_CB_SS];
    assign pwr_min_en = cfg_q[`SCS_CB_PWR_MIN];
    assign bw_mode = cfg_q[`SCS_CB_BW_HI:`SCS_CB_BW_LO];
    assign reconfig_axi_en = axi_q;
    assign primitive_config_port_en = port_q;
endmodule : scs_sequencer
`default_nettype wire

// [shared/scs_cnt_if.sv]
`timescale 1ns/100ps
`default_nettype none
interface scs_cnt_if;
    logic start;
    logic clk_lvl;
    logic done;
    modport main (output start, output clk_lvl, input done);
    modport cnt (input start, input clk_lvl, output done);
endinterface : scs_cnt_if
`default_nettype wire

// [shared/scs_defs.svh]
`ifndef SCS_DEFS_SVH
`define SCS_DEFS_SVH

// ***********************************
// Register map (byte addresses)
// ***********************************
`define SCS_ADDR_W 4
`define SCS_OFF_CTRL 4'h0
`define SCS_OFF_OUT_EN 4'h4
`define SCS_OFF_SEQ 4'h8
`define SCS_OFF_STATUS 4'hC

// ***********************************
// Control register fields
// ***********************************
`define SCS_CTRL_W 9
`define SCS_CTRL_RST 9'h000
`define SCS_CB_SAFE 0
`define SCS_CB_SEQ 1
`define SCS_CB_CLK_SEL 2
`define SCS_CB_SS 3
`define SCS_CB_PWR_MIN 4
`define SCS_CB_DYN 5
`define SCS_CB_PORT 6
`define SCS_CB_BW_LO 7
`define SCS_CB_BW_HI 8

// ***********************************
// Bandwidth choices
// ***********************************
`define SCS_BW_BALANCED 2'h0
`define SCS_BW_MIN_OUT_JIT 2'h1
`define SCS_BW_MAX_IN_FILT 2'h2
`define SCS_BW_ILLEGAL 2'h3

// ***********************************
// Status register fields
// ***********************************
`define SCS_SB_LOCKED 8
`define SCS_SB_QUAL 9
`define SCS_SB_DONE 10

// ***********************************
// Timing counts (cycles)
// ***********************************
`define SCS_LOCK_CYCLES 4'h8
`define SCS_SEQ_GAP 4'h8

`endif

// [shared/scs_pkg.sv]
`default_nettype none
package scs_pkg;
    typedef enum logic [1:0] {
        SCS_QUAL,
        SCS_FIND,
        SCS_WAIT,
        SCS_DONE
    } scs_state_t;
endpackage : scs_pkg
`default_nettype wire

// [verification/safe_clock_startup_sequencer_tb.sv]
`timescale 1ns/100ps
`default_nettype none
`include "scs_defs.svh"
module safe_clock_startup_sequencer_tb;
    logic clock = 1'b0;
    logic rst_n, psel, penable, pwrite, pready, pslverr, lock_req, locked;
    logic clk_sel, ss_en, pwr_min_en, axi_en, port_en;
    logic [3:0] paddr;
    logic [31:0] pwdata, prdata, rd_v;
    logic [6:0] clk_out_mon, gate_en;
    logic [1:0] bw_mode;
    int n_errors = 0;
    int n_compared = 0;
    // 25 MHz reference, inside both ranges
    initial begin
        forever #20 clock = ~clock;
    end
    scs_sequencer i_dut (
        .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .locked(locked),
        .clk_out_mon(clk_out_mon), .gate_en(gate_en), .clk_sel(clk_sel), .ss_en(ss_en),
        .pwr_min_en(pwr_min_en), .bw_mode(bw_mode), .reconfig_axi_en(axi_en),
        .primitive_config_port_en(port_en)
    );
    scs_prim_model i_prim (.clock(clock), .lock_req(lock_req), .locked(locked), .clk_out_mon(clk_out_mon));
    task automatic final_report;
        if (n_errors == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : final_report
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [3:0] a, input logic [31:0] d, input logic e_err);
        int k;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clock);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) begin
            n_errors++;
            final_report();
        end
        rd_v = prdata;
        chk(pslverr, e_err);
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask : apb
    task automatic t_regs;
        logic [31:0] bad [4] = '{32'h18, 32'h28, 32'h0C, 32'h180};
        logic [31:0] good [8] = '{32'h4, 32'h80, 32'h100, 32'h20, 32'h60, 32'h8, 32'h10, 32'h0};
        logic [31:0] v;
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, 4'(i * 4), 32'h0, 1'b0);
            chk(rd_v, 32'h0);
        end
        apb(1'b0, 4'h2, 32'h0, 1'b1);
        apb(1'b1, `SCS_OFF_STATUS, 32'h1, 1'b1);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, `SCS_OFF_CTRL, bad[i], 1'b1);
        end
        apb(1'b0, `SCS_OFF_CTRL, 32'h0, 1'b0);
        chk(rd_v, 32'h0);
        for (int i = 0; i < 8; i++) begin
            v = good[i];
            apb(1'b1, `SCS_OFF_CTRL, v, 1'b0);
            chk({clk_sel, ss_en, pwr_min_en, bw_mode, axi_en, port_en},
                {v[2], v[3], v[4], v[8:7], v[5] & ~v[6], v[5] & v[6]});
            apb(1'b0, `SCS_OFF_CTRL, 32'h0, 1'b0);
            chk(rd_v, v);
        end
        // Safe startup off: gates follow the enables one cycle later
        apb(1'b1, `SCS_OFF_OUT_EN, 32'h55, 1'b0);
        @(posedge clock);
        #1;
        chk(gate_en, 32'h55);
    endtask : t_regs
    task automatic t_safe;
        int k;
        apb(1'b1, `SCS_OFF_CTRL, 32'h1, 1'b0);
        apb(1'b1, `SCS_OFF_OUT_EN, 32'h7F, 1'b0);
        chk(gate_en, 32'h0);
        @(posedge clock);
        lock_req <= 1'b1;
        repeat (7) @(posedge clock);
        lock_req <= 1'b0;
        @(posedge clock);
        lock_req <= 1'b1;
        k = 0;
        do begin
            @(posedge clock);
            #1;
            k++;
        end while (gate_en === 7'h00 && k < 40);
        chk(k, 9);
        chk(gate_en, 32'h7F);
        @(posedge clock);
        lock_req <= 1'b0;
        @(posedge clock);
        #1;
        chk(gate_en, 32'h0);
    endtask : t_safe
    task automatic t_seq;
        logic [6:0] exp [3] = '{7'h02, 7'h0A, 7'h0B};
        logic [6:0] prev;
        int last, n;
        apb(1'b1, `SCS_OFF_CTRL, 32'h3, 1'b0);
        apb(1'b1, `SCS_OFF_OUT_EN, 32'h0B, 1'b0);
        apb(1'b1, `SCS_OFF_SEQ, 32'h202, 1'b0);
        @(posedge clock);
        lock_req <= 1'b1;
        prev = 7'h00;
        last = 0;
        n = 0;
        for (int k = 0; k < 600 && n < 3; k++) begin
            @(posedge clock);
            #1;
            if (gate_en !== prev) begin
                chk(gate_en, exp[n]);
                if (n > 0) chk(k - last >= 29, 1'b1);
                prev = gate_en;
                last = k;
                n++;
            end
        end
        chk(n, 3);
        // The sequencer steps through the empty upper levels, one per cycle
        repeat (10) @(posedge clock);
        apb(1'b0, `SCS_OFF_STATUS, 32'h0, 1'b0);
        chk(rd_v, 32'h70B);
    endtask : t_seq
    task automatic t_reset;
        @(posedge clock);
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        #1;
        chk(gate_en, 32'h0);
        // Lock still high: qualification restarts, gates stay shut
        repeat (10) @(posedge clock);
        apb(1'b0, `SCS_OFF_STATUS, 32'h0, 1'b0);
        chk(rd_v, 32'h300);
        apb(1'b0, `SCS_OFF_CTRL, 32'h0, 1'b0);
        chk(rd_v, 32'h0);
    endtask : t_reset
    initial begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 4'h0;
        pwdata = 32'h0;
        lock_req = 1'b0;
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        t_regs();
        t_safe();
        t_seq();
        t_reset();
        final_report();
    end
endmodule : safe_clock_startup_sequencer_tb
`default_nettype wire

// [verification/scs_monitor.sv]
`timescale 1ns/100ps
`default_nettype none
`include "scs_defs.svh"
module scs_monitor #(
    parameter int NUM_OUT = 7
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`SCS_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic locked,
    input wire logic [NUM_OUT-1:0] gate_en,
    input wire logic clk_sel,
    input wire logic ss_en,
    input wire logic pwr_min_en,
    input wire logic [1:0] bw_mode,
    input wire logic reconfig_axi_en,
    input wire logic primitive_config_port_en
);
    logic wr_ok;
    logic [1:0] mode_q, mode_d;
    logic [3:0] lock_q, lock_d;
    logic [5:0] gap_q, gap_d;
    logic [NUM_OUT-1:0] prev_q, prev_d;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    assign wr_ok = psel && penable && pready && pwrite && !pslverr && paddr == `SCS_OFF_CTRL;
    // Saturating counts, so long waits never wrap into false passes
    always_comb begin
        mode_d = !rst_n ? 2'h0 : (wr_ok ? pwdata[1:0] : mode_q);
        lock_d = !(rst_n && locked) ? 4'h0 : lock_q + {3'h0, lock_q != 4'hF};
        gap_d = (!rst_n || gate_en != prev_q) ? 6'h00 : gap_q + {5'h00, gap_q != 6'h3F};
        prev_d = rst_n ? gate_en : '0;
    end
    always_ff @(posedge clock) begin
        mode_q <= mode_d;
        lock_q <= lock_d;
        gap_q <= gap_d;
        prev_q <= prev_d;
    end
    wait_state_a: assert property (psel && penable && !pready |=> pready && psel && penable)
        else $error("no answer one cycle into access");
    ready_pulse_a: assert property (pready |=> !pready) else $error("pready held two cycles");
    unaligned_err_a: assert property (psel && penable && pready && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("unaligned address accepted");
    lock_qual_a: assert property (mode_q[0] && gate_en != '0 && prev_q == '0 |-> lock_q >= 4'h8)
        else $error("gate opened before lock qualified");
    seq_gap_a: assert property (mode_q == 2'h3 && prev_q != '0 && (gate_en & ~prev_q) != '0
        |-> gap_q >= 6'h0F) else $error("next output opened too soon");
    ref_select_a: assert property (wr_ok |=> clk_sel == $past(pwdata[2]) && bw_mode == $past(pwdata[8:7]))
        else $error("control outputs do not follow write");
    ss_refuse_a: assert property (psel && penable && pready && pwrite && paddr == `SCS_OFF_CTRL
        && pwdata[3] && (pwdata[4] || pwdata[5]) |-> pslverr) else $error("bad combination accepted");
    ss_exclusive_a: assert property (ss_en |-> !(clk_sel || pwr_min_en || reconfig_axi_en
        || primitive_config_port_en)) else $error("feature active with spread spectrum");
    bw_legal_a: assert property (bw_mode != `SCS_BW_ILLEGAL) else $error("both jitter modes on");
    reconfig_path_a: assert property (wr_ok && pwdata[5] |=> reconfig_axi_en != primitive_config_port_en
        && primitive_config_port_en == $past(pwdata[6])) else $error("wrong reconfig path");
    lock_loss_a: assert property (mode_q[0] && !locked |=> gate_en == '0)
        else $error("gates open after lock loss");
endmodule : scs_monitor
bind scs_sequencer scs_monitor #(.NUM_OUT(NUM_OUT)) i_mon (
    .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .locked(locked), .gate_en(gate_en),
    .clk_sel(clk_sel), .ss_en(ss_en), .pwr_min_en(pwr_min_en), .bw_mode(bw_mode),
    .reconfig_axi_en(reconfig_axi_en), .primitive_config_port_en(primitive_config_port_en)
);
`default_nettype wire

// [verification/scs_prim_model.sv]
`timescale 1ns/100ps
`default_nettype none
module scs_prim_model #(
    parameter int NUM_OUT = 7
) (
    input wire logic clock,
    input wire logic lock_req,
    output logic locked,
    output logic [NUM_OUT-1:0] clk_out_mon
);
    logic [1:0] div_q;
    logic [1:0] div_d;
    assign locked = lock_req;
    // Derived clocks idle low until lock, then run at a quarter rate
    always_comb begin
        div_d = lock_req ? div_q + 2'h1 : 2'h0;
    end
    always_ff @(posedge clock) begin
        div_q <= div_d;
    end
    assign clk_out_mon = {NUM_OUT{div_q[1]}};
endmodule : scs_prim_model
`default_nettype wire
